// *** include/lp_sense_pkg.sv ***
package lp_sense_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register map
  localparam logic [7:0] REG_CTRL         = 8'h00;
  localparam logic [7:0] REG_WAKE_THRESH  = 8'h04;
  localparam logic [7:0] REG_CAPTURE_LEN  = 8'h08;
  localparam logic [7:0] REG_ENERGY_LIMIT = 8'h0C;
  localparam logic [7:0] REG_PERIOD       = 8'h10;
  localparam logic [7:0] REG_RESULT       = 8'h14;
  localparam logic [7:0] REG_ENERGY       = 8'h18;
  localparam logic [7:0] REG_STATUS       = 8'h1C;
  localparam logic [7:0] REG_MASK         = 8'h20;
  localparam logic [7:0] REG_STATE        = 8'h24;
  localparam logic [7:0] REG_SAMPLE_INDEX = 8'h28;
  localparam logic [7:0] REG_SAMPLE_DATA  = 8'h2C;

  // Control bits
  localparam int CTRL_START_BIT    = 0;
  localparam int CTRL_PERIODIC_BIT = 1;
  localparam int CTRL_CAPTURE_BIT  = 2;

  // Event bits, shared by status and mask
  localparam int EV_W     = 5;
  localparam int EV_DONE  = 0;
  localparam int EV_WAKE  = 1;
  localparam int EV_BREAK = 2;
  localparam int EV_KNOCK = 3;
  localparam int EV_REED  = 4;

  // Reset values
  localparam logic [7:0]  RST_WAKE_THRESH  = 8'h80;
  localparam logic [7:0]  RST_CAPTURE_LEN  = 8'h40;
  localparam logic [31:0] RST_ENERGY_LIMIT = 32'h0001_0000;
  localparam logic [15:0] RST_PERIOD       = 16'h0020;
  localparam logic [EV_W-1:0] RST_MASK     = 5'h00;

  // Approximation constants; the start code is also the signal midpoint
  localparam logic [7:0] SAR_START_CODE = 8'h80;
  localparam logic [7:0] SAR_FIRST_STEP = 8'h40;
  localparam logic [3:0] SAR_RESOLUTION = 4'h8;

  // Timing
  localparam int CLOCK_HZ        = 50_000_000;
  localparam int SETTLE_US       = 10;
  localparam int SETTLE_CYCLES   = (SETTLE_US * CLOCK_HZ + 999_999) / 1_000_000;
  localparam int WAKE_RATE_HZ    = 32_000;
  localparam int WAKE_DIV_CYCLES = CLOCK_HZ / WAKE_RATE_HZ;

  typedef enum logic [2:0] {
    SAR_IDLE,
    SAR_SETUP,
    SAR_SET_DAC,
    SAR_WAIT_STABLE,
    SAR_SETTLE,
    SAR_DECIDE,
    SAR_FINISH
  } sar_state_t;

endpackage

// *** core/sample_memory.sv ***
`timescale 1ns/1ps
module sample_memory
  import lp_sense_pkg::*;
#(
  parameter int WIDTH  = 8,
  parameter int ADDR_B = 8
)(
  input  wire logic              clock,
  input  wire logic              wr_en,
  input  wire logic [ADDR_B-1:0] wr_addr,
  input  wire logic [WIDTH-1:0]  wr_data,
  input  wire logic [ADDR_B-1:0] rd_addr,
  output logic      [WIDTH-1:0]  rd_data
);

  logic [WIDTH-1:0] store [0:(1<<ADDR_B)-1];

  always_ff @(posedge clock)
  begin
    if (wr_en)
    begin
      store[wr_addr] <= wr_data;
    end
    rd_data <= store[rd_addr];
  end

endmodule

// *** core/wake_sampler.sv ***
`timescale 1ns/1ps
module wake_sampler
  import lp_sense_pkg::*;
#(
  parameter int DIV = WAKE_DIV_CYCLES
)(
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic wake_comparator,
  output logic      tick,
  output logic      decision
);

  typedef struct packed {
    logic [10:0] count;
    logic        tick;
    logic        decision;
  } sampler_t;

  sampler_t s;
  sampler_t next_s;

  always_comb
  begin
    next_s = s;
    next_s.tick = 1'b0;
    if (s.count == 11'(DIV - 1))
    begin
      next_s.count    = 11'h000;
      next_s.tick     = 1'b1;
      next_s.decision = wake_comparator;
    end
    else
    begin
      next_s.count = s.count + 11'h001;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign tick     = s.tick;
  assign decision = s.decision;

  a_decision_on_tick: assert property (@(posedge clock) disable iff (!rst_n)
    $changed(s.decision) |-> s.tick)
    else $error("wake decision changed off a sample instant");

endmodule

// *** core/low_power_sar_adc_wake_detector.sv ***
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Wake comparator decides only at 32kHz instants
// - Wake comparator crossing raises wake request
// - Wake threshold comes from programmed reference DAC
// - Threshold crossing starts fixed-length sample capture
// - Capture energy separates break from knock
// - Reed input low means switch closed
// - 8-bit approximation from comparator and DAC
// - High-frequency converter never used here
// - Sample-and-hold steady through whole conversion
// - Logic drives DAC, comparator reports input above
// - Start: trial 0x80, result cleared, DAC on
// - Trial up by step if larger, else down
// - Step starts 64, halves each trial, eight trials
// - Wait DAC stable, then 10us before sampling
// - OR decision into result at decremented index
// - End: stop DAC, ground reference, disable, reschedule
//////////////////////////////////////////////////////////////////////////////
module low_power_sar_adc_wake_detector
  import lp_sense_pkg::*;
#(
  parameter int MEM_ADDR_B = 8
)(
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wr_data,
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  output logic      [DATA_W-1:0] rd_data,
  input  wire logic              sar_comparator,
  input  wire logic              dac_stable,
  input  wire logic              wake_comparator,
  input  wire logic              reed_n,
  output logic      [7:0]        dac_code,
  output logic                   dac_enable,
  output logic                   dac_output_on,
  output logic                   supply_reference_select,
  output logic                   sar_comp_enable,
  output logic                   ground_reference_select,
  output logic                   sample_hold,
  output logic      [7:0]        wake_threshold,
  output logic                   high_freq_adc_enable,
  output logic                   wake_request,
  output logic                   irq,
  output logic                   conv_done,
  output logic      [7:0]        conv_result
);

  typedef struct packed {
    sar_state_t      st;
    logic [7:0]      dac_trial_value;
    logic [7:0]      step;
    logic [3:0]      bit_index;
    logic            compare_result;
    logic [7:0]      result;
    logic [9:0]      settle_count;
    logic            periodic;
    logic            capture_en;
    logic [7:0]      wake_thresh;
    logic [7:0]      capture_len;
    logic [31:0]     energy_limit;
    logic [15:0]     period;
    logic [15:0]     period_count;
    logic            sched_pending;
    logic            capturing;
    logic [7:0]      capture_count;
    logic [31:0]     energy;
    logic [31:0]     last_energy;
    logic [EV_W-1:0] status;
    logic [EV_W-1:0] mask;
    logic            wake_prev;
    logic            reed_n_q;
    logic            reed_closed;
    logic [7:0]      sample_index;
    logic            mem_we;
    logic [7:0]      mem_waddr;
    logic [7:0]      mem_wdata;
    logic [31:0]     rd_data;
    logic [7:0]      dac_code;
    logic            dac_enable;
    logic            dac_output_on;
    logic            supply_ref;
    logic            comp_enable;
    logic            ground_ref;
    logic            sample_hold;
    logic            hf_enable;
    logic            wake_request;
    logic            irq;
    logic            conv_done;
    logic [7:0]      conv_result;
  } core_t;

  core_t s;
  core_t next_s;

  logic       wake_tick;
  logic       wake_decision;
  logic [7:0] mem_rd_data;

  wake_sampler #(
    .DIV (WAKE_DIV_CYCLES)
  ) wake_sampler_i (
    .clock           (clock),
    .rst_n           (rst_n),
    .wake_comparator (wake_comparator),
    .tick            (wake_tick),
    .decision        (wake_decision)
  );

  sample_memory #(
    .WIDTH  (8),
    .ADDR_B (MEM_ADDR_B)
  ) sample_memory_i (
    .clock   (clock),
    .wr_en   (s.mem_we),
    .wr_addr (s.mem_waddr[MEM_ADDR_B-1:0]),
    .wr_data (s.mem_wdata),
    .rd_addr (s.sample_index[MEM_ADDR_B-1:0]),
    .rd_data (mem_rd_data)
  );

  //////////////////////////////////////////////////////////////////////////////
  logic [EV_W-1:0]   events;
  logic              start_req;
  logic              wake_event;
  logic signed [8:0] diff;
  logic [17:0]       square;
  logic [31:0]       sum;
  logic [2:0]        bit_pos;

  always_comb
  begin
    next_s     = s;
    events     = '0;
    diff       = $signed({1'b0, s.result}) - $signed({1'b0, SAR_START_CODE});
    square     = 18'(diff) * 18'(diff);
    sum        = s.energy + {14'h0000, square};
    bit_pos    = 3'(s.bit_index - 4'h1);
    wake_event = wake_decision && !s.wake_prev;
    next_s.wake_prev = wake_decision;
    next_s.mem_we    = 1'b0;
    next_s.conv_done = 1'b0;
    next_s.hf_enable = 1'b0;

    // Reed contact
    next_s.reed_n_q    = reed_n;
    next_s.reed_closed = !reed_n;
    if (reed_n != s.reed_n_q)
    begin
      events[EV_REED] = 1'b1;
    end

    // Wake and capture trigger
    if (wake_event)
    begin
      events[EV_WAKE] = 1'b1;
      if (s.capture_en && !s.capturing)
      begin
        next_s.capturing     = 1'b1;
        next_s.capture_count = 8'h00;
        next_s.energy        = 32'h0000_0000;
      end
    end

    // Periodic schedule on the slow tick
    if (wake_tick && s.periodic && s.period_count != 16'h0000)
    begin
      next_s.period_count = s.period_count - 16'h0001;
      if (s.period_count == 16'h0001)
      begin
        next_s.sched_pending = 1'b1;
      end
    end

    // Register writes
    start_req = s.sched_pending || s.capturing;
    if (wr_en)
    begin
      case (addr)
        REG_CTRL:
        begin
          start_req         = start_req || wr_data[CTRL_START_BIT];
          next_s.periodic   = wr_data[CTRL_PERIODIC_BIT];
          next_s.capture_en = wr_data[CTRL_CAPTURE_BIT];
        end
        REG_WAKE_THRESH:  next_s.wake_thresh  = wr_data[7:0];
        REG_CAPTURE_LEN:  next_s.capture_len  = wr_data[7:0];
        REG_ENERGY_LIMIT: next_s.energy_limit = wr_data;
        REG_PERIOD:       next_s.period       = wr_data[15:0];
        REG_MASK:         next_s.mask         = wr_data[EV_W-1:0];
        REG_SAMPLE_INDEX: next_s.sample_index = wr_data[7:0];
        default:          next_s.periodic     = s.periodic;
      endcase
    end

    // Approximation sequence
    case (s.st)
      SAR_IDLE:
      begin
        if (start_req)
        begin
          next_s.st            = SAR_SETUP;
          next_s.sched_pending = 1'b0;
        end
      end
      SAR_SETUP:
      begin
        next_s.dac_trial_value = SAR_START_CODE;
        next_s.result          = 8'h00;
        next_s.step            = SAR_FIRST_STEP;
        next_s.bit_index       = SAR_RESOLUTION;
        next_s.comp_enable     = 1'b1;
        next_s.dac_output_on   = 1'b1;
        next_s.dac_enable      = 1'b1;
        next_s.supply_ref      = 1'b1;
        next_s.ground_ref      = 1'b0;
        next_s.sample_hold     = 1'b1;
        next_s.st              = SAR_SET_DAC;
      end
      SAR_SET_DAC:
      begin
        next_s.dac_code     = s.dac_trial_value;
        next_s.settle_count = 10'h000;
        next_s.st           = SAR_WAIT_STABLE;
      end
      SAR_WAIT_STABLE:
      begin
        if (dac_stable)
        begin
          next_s.st = SAR_SETTLE;
        end
      end
      SAR_SETTLE:
      begin
        if (s.settle_count == 10'(SETTLE_CYCLES - 1))
        begin
          next_s.st = SAR_DECIDE;
        end
        else
        begin
          next_s.settle_count = s.settle_count + 10'h001;
        end
      end
      SAR_DECIDE:
      begin
        next_s.compare_result = sar_comparator;
        if (sar_comparator)
        begin
          next_s.dac_trial_value = s.dac_trial_value + s.step;
        end
        else
        begin
          next_s.dac_trial_value = s.dac_trial_value - s.step;
        end
        next_s.step      = s.step >> 1;
        next_s.bit_index = s.bit_index - 4'h1;
        next_s.result    = s.result | (8'(sar_comparator) << bit_pos);
        next_s.st        = (s.bit_index == 4'h1) ? SAR_FINISH : SAR_SET_DAC;
      end
      SAR_FINISH:
      begin
        next_s.dac_output_on = 1'b0;
        next_s.ground_ref    = 1'b1;
        next_s.dac_enable    = 1'b0;
        next_s.comp_enable   = 1'b0;
        next_s.supply_ref    = 1'b0;
        next_s.sample_hold   = 1'b0;
        next_s.conv_done     = 1'b1;
        next_s.conv_result   = s.result;
        events[EV_DONE]      = 1'b1;
        next_s.st            = SAR_IDLE;
        if (s.periodic)
        begin
          next_s.period_count = s.period;
        end
        if (s.capturing)
        begin
          next_s.mem_we        = 1'b1;
          next_s.mem_waddr     = s.capture_count;
          next_s.mem_wdata     = s.result;
          next_s.energy        = sum;
          next_s.capture_count = s.capture_count + 8'h01;
          if (s.capture_count == s.capture_len - 8'h01)
          begin
            next_s.capturing   = 1'b0;
            next_s.last_energy = sum;
            if (sum > s.energy_limit)
            begin
              events[EV_BREAK] = 1'b1;
            end
            else
            begin
              events[EV_KNOCK] = 1'b1;
            end
          end
        end
      end
      default:
      begin
        next_s.st = SAR_IDLE;
      end
    endcase

    // Register reads, one cycle later
    next_s.rd_data = 32'h0000_0000;
    if (rd_en)
    begin
      case (addr)
        REG_CTRL:         next_s.rd_data = {29'h0, s.capture_en, s.periodic, 1'b0};
        REG_WAKE_THRESH:  next_s.rd_data = {24'h0, s.wake_thresh};
        REG_CAPTURE_LEN:  next_s.rd_data = {24'h0, s.capture_len};
        REG_ENERGY_LIMIT: next_s.rd_data = s.energy_limit;
        REG_PERIOD:       next_s.rd_data = {16'h0, s.period};
        REG_RESULT:       next_s.rd_data = {24'h0, s.conv_result};
        REG_ENERGY:       next_s.rd_data = s.last_energy;
        REG_STATUS:       next_s.rd_data = {27'h0, s.status};
        REG_MASK:         next_s.rd_data = {27'h0, s.mask};
        REG_STATE:        next_s.rd_data = {27'h0, s.reed_closed, wake_decision,
                                            s.capturing, s.st != SAR_IDLE, s.sched_pending};
        REG_SAMPLE_INDEX: next_s.rd_data = {24'h0, s.sample_index};
        REG_SAMPLE_DATA:  next_s.rd_data = {24'h0, mem_rd_data};
        default:          next_s.rd_data = 32'h0000_0000;
      endcase
    end

    // Sticky events; a set in the clearing read's cycle survives
    if (rd_en && addr == REG_STATUS)
    begin
      next_s.status = events;
    end
    else
    begin
      next_s.status = s.status | events;
    end
    next_s.irq          = |(next_s.status & s.mask);
    next_s.wake_request = next_s.status[EV_WAKE];
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s              <= '0;
      s.st           <= SAR_IDLE;
      s.wake_thresh  <= RST_WAKE_THRESH;
      s.capture_len  <= RST_CAPTURE_LEN;
      s.energy_limit <= RST_ENERGY_LIMIT;
      s.period       <= RST_PERIOD;
      s.mask         <= RST_MASK;
      s.reed_n_q     <= 1'b1;
      s.ground_ref   <= 1'b1;
    end
    else
    begin
      s <= next_s;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  assign rd_data                 = s.rd_data;
  assign dac_code                = s.dac_code;
  assign dac_enable              = s.dac_enable;
  assign dac_output_on           = s.dac_output_on;
  assign supply_reference_select = s.supply_ref;
  assign sar_comp_enable         = s.comp_enable;
  assign ground_reference_select = s.ground_ref;
  assign sample_hold             = s.sample_hold;
  assign wake_threshold          = s.wake_thresh;
  assign high_freq_adc_enable    = s.hf_enable;
  assign wake_request            = s.wake_request;
  assign irq                     = s.irq;
  assign conv_done               = s.conv_done;
  assign conv_result             = s.conv_result;

  //////////////////////////////////////////////////////////////////////////////
  a_setup_loads: assert property (@(posedge clock) disable iff (!rst_n)
    s.st == SAR_SETUP |=> s.dac_trial_value == SAR_START_CODE && s.result == 8'h00
                          && s.step == SAR_FIRST_STEP && dac_enable && supply_reference_select)
    else $error("conversion start did not load trial and clear result");

  a_hold_steady: assert property (@(posedge clock) disable iff (!rst_n)
    (s.st == SAR_SET_DAC || s.st == SAR_SETTLE || s.st == SAR_DECIDE) |-> sample_hold)
    else $error("sample hold released during conversion");

  a_step_halves: assert property (@(posedge clock) disable iff (!rst_n)
    s.st == SAR_DECIDE |=> s.step == ($past(s.step) >> 1)
                           && s.bit_index == $past(s.bit_index) - 4'h1)
    else $error("step not halved after trial");

  a_trial_moves: assert property (@(posedge clock) disable iff (!rst_n)
    s.st == SAR_DECIDE |=> s.dac_trial_value == ($past(sar_comparator)
      ? $past(s.dac_trial_value) + $past(s.step) : $past(s.dac_trial_value) - $past(s.step)))
    else $error("trial value moved the wrong way");

  a_settle_wait: assert property (@(posedge clock) disable iff (!rst_n)
    s.st == SAR_DECIDE |-> $past(s.st) == SAR_SETTLE
                           && $past(s.settle_count) == 10'(SETTLE_CYCLES - 1))
    else $error("comparator sampled before settle time");

  a_done_pulse: assert property (@(posedge clock) disable iff (!rst_n)
    conv_done |-> conv_result == $past(s.result) ##1 !conv_done)
    else $error("done pulse not single cycle with result");

  a_finish_off: assert property (@(posedge clock) disable iff (!rst_n)
    conv_done |-> !dac_enable && !sar_comp_enable && !dac_output_on && ground_reference_select)
    else $error("peripherals left on after conversion");

  a_hf_unused: assert property (@(posedge clock) disable iff (!rst_n)
    !high_freq_adc_enable)
    else $error("high-frequency converter enabled");

  a_reed_level: assert property (@(posedge clock) disable iff (!rst_n)
    s.reed_closed == !$past(reed_n))
    else $error("reed level not inverted");

  a_wake_raise: assert property (@(posedge clock) disable iff (!rst_n)
    (wake_decision && !s.wake_prev) |=> wake_request)
    else $error("wake crossing did not raise wake request");

endmodule

// *** verif/analog_front_end.sv ***
`timescale 1ns/1ps
module analog_front_end
  import lp_sense_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       slow,
  input  wire logic [7:0] vin,
  input  wire logic [7:0] dac_code,
  input  wire logic       dac_enable,
  input  wire logic       dac_output_on,
  input  wire logic       supply_reference_select,
  input  wire logic       sar_comp_enable,
  input  wire logic       sample_hold,
  input  wire logic [7:0] wake_threshold,
  output logic            sar_comparator,
  output logic            dac_stable,
  output logic            wake_comparator
);
  logic [7:0] held      = 8'h00;
  logic [7:0] last_code = 8'h00;
  logic       was_hold  = 1'b0;
  logic       flip      = 1'b0;
  int         wait_n    = 0;
  int         since     = 0;

  always @(posedge clock)
  begin
    flip <= ~flip;
    was_hold <= sample_hold;
    if (sample_hold && !was_hold)
      held <= vin;
    last_code <= dac_code;
    if (dac_code != last_code)
      wait_n <= slow ? 6 : 1;
    else if (wait_n > 0)
      wait_n <= wait_n - 1;
    if (dac_code != last_code)
      since <= 0;
    else if (dac_stable)
      since <= since + 1;
  end

  // Stable only once the code has stood and the settling count ran out
  assign dac_stable = dac_enable && (dac_code == last_code) && (wait_n == 0);
  // Unpowered comparator gives a changing level, not a held one
  // Decision only valid once the output stood stable for the settle wait
  assign sar_comparator = (sar_comp_enable && dac_output_on && supply_reference_select
                           && since >= SETTLE_CYCLES) ? (held > dac_code) : flip;
  assign wake_comparator = vin > wake_threshold;
endmodule

// *** verif/low_power_sar_adc_wake_detector_tb.sv ***
`timescale 1ns/1ps
module low_power_sar_adc_wake_detector_tb;
  import lp_sense_pkg::*;
  logic              clock   = 1'b0;
  logic              rst_n   = 1'b0;
  logic [ADDR_W-1:0] addr    = '0;
  logic [DATA_W-1:0] wr_data = '0;
  logic              wr_en   = 1'b0;
  logic              rd_en   = 1'b0;
  logic              reed_n  = 1'b1;
  logic              slow    = 1'b0;
  logic [7:0]        vin     = 8'h00;
  logic              rd_seen = 1'b0;
  logic [DATA_W-1:0] rd_data;
  logic [7:0]        dac_code, wake_threshold, conv_result;
  logic              sar_comparator, dac_stable, wake_comparator, dac_enable, dac_output_on;
  logic              supply_reference_select, sar_comp_enable, ground_reference_select;
  logic              sample_hold, high_freq_adc_enable, wake_request, irq, conv_done;
  logic [7:0]        cq[$];
  logic [32:0]       rq[$];
  logic [32:0]       e;
  logic [31:0]       seed    = 32'h6C1D;
  int                bad_count = 0;
  int                total_checks = 0;
  int                cycles  = 0;

  low_power_sar_adc_wake_detector low_power_sar_adc_wake_detector_i (
    .clock, .rst_n, .addr, .wr_data, .wr_en, .rd_en, .rd_data, .sar_comparator,
    .dac_stable, .wake_comparator, .reed_n, .dac_code, .dac_enable, .dac_output_on,
    .supply_reference_select, .sar_comp_enable, .ground_reference_select, .sample_hold,
    .wake_threshold, .high_freq_adc_enable, .wake_request, .irq, .conv_done, .conv_result
  );

  analog_front_end analog_front_end_i (
    .clock, .slow, .vin, .dac_code, .dac_enable, .dac_output_on, .supply_reference_select,
    .sar_comp_enable, .sample_hold, .wake_threshold, .sar_comparator, .dac_stable,
    .wake_comparator
  );

  always #10 clock = ~clock;

  //////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %0t %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task complete_run;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction

  // Successive approximation, most significant bit first
  function automatic logic [7:0] sar_expect(input logic [7:0] v);
    int         t;
    int         s;
    logic [7:0] r;
    t = 128;
    s = 64;
    r = '0;
    for (int b = 7; b >= 0; b--)
    begin
      r[b] = int'(v) > t;
      t = r[b] ? t + s : t - s;
      s = s >> 1;
    end
    return r;
  endfunction

  function automatic int energy(input logic [7:0] v);
    int d;
    d = int'(sar_expect(v)) - 128;
    return 2 * d * d;
  endfunction

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic care, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    rd_en <= 1'b1;
    rq.push_back({care, d});
    @(posedge clock);
    rd_en <= 1'b0;
  endtask

  task drain;
    for (int i = 0; i < 14000 && cq.size() > 0; i++)
      @(posedge clock);
    chk(cq.size(), 0, "conversion missing");
  endtask

  // Second start lands while busy and must be dropped
  task convert(input logic [7:0] v);
    vin <= v;
    cq.push_back(sar_expect(v));
    wr(REG_CTRL, 32'h1);
    wr(REG_CTRL, 32'h1);
    repeat (5) @(posedge clock);
    vin <= ~v;
    drain();
  endtask

  task capture(input logic [7:0] v, input logic [31:0] st, input logic ir);
    vin <= 8'h00;
    repeat (2 * WAKE_DIV_CYCLES + 10) @(posedge clock);
    rd(REG_STATUS, 1'b0, 0);
    cq.push_back(sar_expect(v));
    cq.push_back(sar_expect(v));
    vin <= v;
    for (int i = 0; i < 4000 && wake_request !== 1'b1; i++)
      @(posedge clock);
    chk(wake_request, 1, "wake request");
    drain();
    repeat (3) @(posedge clock);
    chk(irq, ir, "irq after capture");
    rd(REG_ENERGY, 1'b1, energy(v));
    wr(REG_SAMPLE_INDEX, 32'h1);
    rd(REG_SAMPLE_DATA, 1'b1, {24'h0, sar_expect(v)});
    rd(REG_STATUS, 1'b1, st);
    $display("capture test done");
  endtask

  //////////////////////////////////////////////////////////////////////////////
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    rd_seen <= rd_en;
    if (rd_seen)
    begin
      e = rq.pop_front();
      if (e[32])
        chk(rd_data, e[31:0], "read data");
    end
    if (conv_done)
    begin
      chk(cq.size() > 0, 1, "unexpected done");
      if (cq.size() > 0)
        chk(conv_result, cq.pop_front(), "result");
      chk({ground_reference_select, dac_enable, dac_output_on, sar_comp_enable,
           supply_reference_select, high_freq_adc_enable}, 6'b100000, "finish");
    end
    if (cycles == 80000)
    begin
      bad_count++;
      $display("ERROR %0t timeout", $time);
      complete_run();
    end
  end

  initial
  begin
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    rd(REG_WAKE_THRESH, 1'b1, 32'h80);
    rd(REG_CAPTURE_LEN, 1'b1, 32'h40);
    rd(REG_ENERGY_LIMIT, 1'b1, 32'h0001_0000);
    rd(REG_PERIOD, 1'b1, 32'h20);
    rd(REG_MASK, 1'b1, 32'h0);
    wr(8'h30, 32'hFF);
    rd(8'h30, 1'b1, 32'h0);
    rd(REG_STATUS, 1'b0, 0);
    chk({ground_reference_select, high_freq_adc_enable}, 2'b10, "reset outputs");
    $display("reset test done");
    reed_n <= 1'b0;
    repeat (4) @(posedge clock);
    rd(REG_STATE, 1'b1, 32'h10);
    rd(REG_STATUS, 1'b1, 32'h10);
    reed_n <= 1'b1;
    repeat (4) @(posedge clock);
    rd(REG_STATE, 1'b1, 32'h00);
    rd(REG_STATUS, 1'b1, 32'h10);
    $display("reed test done");
    wr(REG_WAKE_THRESH, 32'hFF);
    wr(REG_MASK, 32'h01);
    rd(REG_WAKE_THRESH, 1'b1, 32'hFF);
    chk(wake_threshold, 8'hFF, "threshold code");
    convert(8'h00);
    convert(8'hFF);
    for (int i = 0; i < 4; i++)
    begin
      seed = xs(seed);
      slow <= seed[8];
      convert(seed[7:0]);
    end
    chk(irq, 1, "irq on done");
    rd(REG_RESULT, 1'b1, {24'h0, sar_expect(seed[7:0])});
    rd(REG_STATUS, 1'b1, 32'h01);
    repeat (2) @(posedge clock);
    chk(irq, 0, "irq cleared");
    $display("conversion test done");
    vin <= 8'h00;
    wr(REG_MASK, 32'h04);
    wr(REG_WAKE_THRESH, 32'd200);
    wr(REG_CAPTURE_LEN, 32'd2);
    wr(REG_ENERGY_LIMIT, 32'd20000);
    wr(REG_CTRL, 32'h4);
    rd(REG_CTRL, 1'b1, 32'h4);
    capture(8'd250, 32'h07, 1'b1);
    capture(8'd210, 32'h0B, 1'b0);
    wr(REG_CTRL, 32'h0);
    wr(REG_PERIOD, 32'h2);
    vin <= 8'd77;
    cq.push_back(sar_expect(8'd77));
    cq.push_back(sar_expect(8'd77));
    wr(REG_CTRL, 32'h3);
    drain();
    $display("periodic test done");
    complete_run();
  end
endmodule
